// File: src/bisq_brake_interlock_sequencer.sv
// Brake interlock sequencer: times the brake release request against servo
// ON, servo OFF and alarm, with an APB register file.
// Assumes pin inputs are asynchronous and the speed word is same-domain.
`timescale 1ns/1ps
module bisq_brake_interlock_sequencer
  import bisq_pkg::*;
#(
  parameter int unsigned TICK = TICK_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_servo_on,
  input wire logic i_alarm,
  input wire logic i_main_power_ok,
  input wire logic [15:0] i_speed_rpm,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_brake_release_request,
  output logic o_motor_power,
  output logic o_dynamic_brake,
  output logic o_alarm
);
  // Two-stage synchronisers for the pin inputs
  logic [2:0] sync1_reg, sync2_reg;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {i_main_power_ok, i_alarm, i_servo_on};
      sync2_reg <= sync1_reg;
    end
  end
  logic son_s, alm_s, pwr_ok_s;
  assign son_s = sync2_reg[0];
  assign alm_s = sync2_reg[1];
  assign pwr_ok_s = sync2_reg[2];

  // Register file
  logic [15:0] stop_dly_reg, stop_dly_next;
  logic [15:0] run_dly_reg, run_dly_next;
  logic [15:0] clr_spd_reg, clr_spd_next;
  logic db_sel_reg, db_sel_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] status_w;
  logic addr_ok;
  logic apb_set;

  // Setup cycle latches the answer, so every access completes in its first access cycle
  assign apb_set = i_psel && !i_penable;
  assign addr_ok = (i_paddr == OFF_CTRL) || (i_paddr == OFF_STOP_DLY) ||
                   (i_paddr == OFF_RUN_DLY) || (i_paddr == OFF_CLR_SPD) ||
                   (i_paddr == OFF_STATUS);

  always_comb begin
    stop_dly_next = stop_dly_reg;
    run_dly_next = run_dly_reg;
    clr_spd_next = clr_spd_reg;
    db_sel_next = db_sel_reg;
    prdata_next = prdata_reg;
    pready_next = apb_set;
    pslverr_next = apb_set && !addr_ok;
    if (apb_set && !i_pwrite) begin
      unique case (i_paddr)
        OFF_CTRL: prdata_next = {31'h0, db_sel_reg};
        OFF_STOP_DLY: prdata_next = {16'h0, stop_dly_reg};
        OFF_RUN_DLY: prdata_next = {16'h0, run_dly_reg};
        OFF_CLR_SPD: prdata_next = {16'h0, clr_spd_reg};
        OFF_STATUS: prdata_next = status_w;
        default: prdata_next = 32'h0;
      endcase
    end
    // Writes take effect at the completing edge
    if (i_psel && i_penable && pready_reg && i_pwrite) begin
      unique case (i_paddr)
        OFF_CTRL: db_sel_next = i_pwdata[CTRL_DB_BIT];
        OFF_STOP_DLY: stop_dly_next = i_pwdata[15:0];
        OFF_RUN_DLY: run_dly_next = i_pwdata[15:0];
        OFF_CLR_SPD: clr_spd_next = i_pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      stop_dly_reg <= RST_STOP_DLY;
      run_dly_reg <= RST_RUN_DLY;
      clr_spd_reg <= RST_CLR_SPD;
      db_sel_reg <= RST_DB_SEL;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      stop_dly_reg <= stop_dly_next;
      run_dly_reg <= run_dly_next;
      clr_spd_reg <= clr_spd_next;
      db_sel_reg <= db_sel_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Sequencer
  bisq_state_e state_reg, state_next;
  logic brk_reg, brk_next;
  logic pwr_reg, pwr_next;
  logic db_reg, db_next;
  logic alm_reg, alm_next;
  logic son_arm_reg, son_arm_next;
  logic son_d_reg;
  logic tmr_start;
  logic tmr_done;
  logic fault;
  logic stopped;
  logic below_clr;

  assign stopped = i_speed_rpm <= {8'h00, SPEED_STOP_RPM};
  assign below_clr = i_speed_rpm <= clr_spd_reg;
  // Lost main power while energised counts as an alarm
  assign fault = alm_s || (pwr_reg && !pwr_ok_s);

  bisq_ms_timer #(
    .TICK(TICK)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_start(tmr_start),
    .i_ms((state_next == BISQ_STOP_DLY) ? stop_dly_reg : run_dly_reg),
    .o_done(tmr_done)
  );

  always_comb begin
    state_next = state_reg;
    brk_next = brk_reg;
    pwr_next = pwr_reg;
    db_next = db_reg;
    alm_next = alm_reg || fault;
    son_arm_next = son_arm_reg;
    tmr_start = 1'b0;
    // A fresh rising edge of servo ON arms entry; an alarm disarms it
    if (son_s && !son_d_reg) begin
      son_arm_next = 1'b1;
    end
    if (!son_s || fault) begin
      son_arm_next = 1'b0;
    end
    if (!fault && !alm_s && pwr_ok_s && alm_reg && !pwr_reg) begin
      alm_next = 1'b0;
    end
    unique case (state_reg)
      BISQ_OFF: begin
        brk_next = 1'b0;
        pwr_next = 1'b0;
        // Entry waits for standstill, also after a decelerating stop
        if (son_arm_reg && son_s && !fault && !alm_reg && stopped) begin
          state_next = BISQ_ON;
          pwr_next = 1'b1;
          brk_next = 1'b1;
          db_next = 1'b0;
        end
      end
      BISQ_ON: begin
        brk_next = 1'b1;
        if (fault) begin
          state_next = BISQ_RUN_DLY;
          tmr_start = 1'b1;
          db_next = db_sel_reg;
        end else if (!son_s) begin
          db_next = db_sel_reg;
          tmr_start = 1'b1;
          state_next = stopped ? BISQ_STOP_DLY : BISQ_RUN_DLY;
        end
      end
      BISQ_STOP_DLY: begin
        if (fault) begin
          state_next = BISQ_RUN_DLY;
          tmr_start = 1'b1;
        end else if (tmr_done) begin
          state_next = BISQ_OFF;
          brk_next = 1'b0;
          pwr_next = 1'b0;
        end
      end
      BISQ_RUN_DLY: begin
        if (tmr_done || below_clr) begin
          state_next = BISQ_OFF;
          brk_next = 1'b0;
          pwr_next = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_reg <= BISQ_OFF;
      brk_reg <= 1'b0;
      pwr_reg <= 1'b0;
      db_reg <= RST_DB_SEL;
      alm_reg <= 1'b0;
      son_arm_reg <= 1'b0;
      son_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      brk_reg <= brk_next;
      pwr_reg <= pwr_next;
      db_reg <= db_next;
      alm_reg <= alm_next;
      son_arm_reg <= son_arm_next;
      son_d_reg <= son_s;
    end
  end

  assign status_w = {26'h0, state_reg, db_reg, pwr_reg, brk_reg, (state_reg == BISQ_ON)};
  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_brake_release_request = brk_reg;
  assign o_motor_power = pwr_reg;
  assign o_dynamic_brake = db_reg;
  assign o_alarm = alm_reg;

  // Assertions
  sequence s_go_on;
    state_reg == BISQ_OFF && state_next == BISQ_ON;
  endsequence
  sequence s_brk_up;
    ##1 brk_reg && pwr_reg;
  endsequence

  on_entry_still_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    s_go_on |-> stopped) else $error("Servo ON entered while motor turning");
  on_hold_brk_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg == BISQ_ON |-> brk_reg) else $error("Brake dropped during servo ON");
  on_release_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    s_go_on |-> s_brk_up) else $error("Brake not released on servo ON");
  clr_speed_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg == BISQ_RUN_DLY && below_clr |=> !brk_reg && state_reg == BISQ_OFF)
    else $error("Brake kept past clear speed");
  stop_wait_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg == BISQ_STOP_DLY && !tmr_done && !fault |=> brk_reg)
    else $error("Brake dropped before stopped delay");
  alarm_path_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg == BISQ_ON && fault |=> state_reg == BISQ_RUN_DLY && db_reg == $past(db_sel_reg))
    else $error("Alarm not sequenced");
  off_db_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg == BISQ_ON && !fault && !son_s |=> db_reg == $past(db_sel_reg))
    else $error("Dynamic brake ignores stop selection");
  no_rearm_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    fault |=> !son_arm_reg) else $error("Servo ON kept armed through alarm");
  power_loss_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    pwr_reg && !pwr_ok_s |=> alm_reg) else $error("Power loss raised no alarm");
  // Delay states keep the brake released until the timer or the clear speed ends them
  run_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg == BISQ_RUN_DLY && !tmr_done && !below_clr |=> brk_reg && pwr_reg)
    else $error("Brake dropped before running delay");
  run_entry_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg == BISQ_ON && !fault && !son_s && !stopped |=> state_reg == BISQ_RUN_DLY)
    else $error("Rotating servo OFF skipped running delay");
  stop_entry_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg == BISQ_ON && !fault && !son_s && stopped |=> state_reg == BISQ_STOP_DLY)
    else $error("Stopped servo OFF skipped stopped delay");
  stop_fault_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg == BISQ_STOP_DLY && fault |=> state_reg == BISQ_RUN_DLY)
    else $error("Alarm in stopped delay not sequenced");
  brk_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg != BISQ_OFF |-> brk_reg)
    else $error("Brake request low outside servo OFF");
  // Nothing stays energised in servo OFF, and leaving it needs a stopped, freshly armed motor
  off_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg == BISQ_OFF |-> !brk_reg && !pwr_reg)
    else $error("Brake or power left on in servo OFF");
  still_wait_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg == BISQ_OFF && !stopped |=> state_reg == BISQ_OFF)
    else $error("Servo ON entered while decelerating");
  fresh_on_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg == BISQ_OFF && !son_arm_reg |=> state_reg == BISQ_OFF)
    else $error("Servo ON entered without a fresh request");
  alarm_latch_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    fault |=> alm_reg)
    else $error("Alarm not latched");
endmodule // bisq_brake_interlock_sequencer

// File: src/bisq_ms_timer.sv
// Millisecond down-counter used for the brake delays.
// Assumes start is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ps
module bisq_ms_timer
  import bisq_pkg::*;
#(
  parameter int unsigned TICK = TICK_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [15:0] i_ms,
  output logic o_done
);
  logic [15:0] ms_reg, ms_next;
  logic [15:0] tick_reg, tick_next;
  logic run_reg, run_next;
  logic done_reg, done_next;

  always_comb begin
    ms_next = ms_reg;
    tick_next = tick_reg;
    run_next = run_reg;
    done_next = 1'b0;
    if (i_start) begin
      ms_next = i_ms;
      tick_next = 16'(TICK - 1);
      run_next = 1'b1;
      // A zero delay expires on the next cycle
      if (i_ms == 16'h0000) begin
        run_next = 1'b0;
        done_next = 1'b1;
      end
    end else if (run_reg) begin
      if (tick_reg == 16'h0000) begin
        tick_next = 16'(TICK - 1);
        if (ms_reg == 16'h0001) begin
          run_next = 1'b0;
          done_next = 1'b1;
        end
        ms_next = ms_reg - 16'h0001;
      end else begin
        tick_next = tick_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ms_reg <= 16'h0000;
      tick_reg <= 16'h0000;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      ms_reg <= ms_next;
      tick_reg <= tick_next;
      run_reg <= run_next;
      done_reg <= done_next;
    end
  end

  assign o_done = done_reg;
endmodule // bisq_ms_timer

// File: src/bisq_pkg.sv
// Package for the brake interlock sequencer: register map, field layout, timing.
// Assumes a 40 MHz drive clock; delays are programmed in milliseconds.
package bisq_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [7:0] SPEED_STOP_RPM = 8'h1E;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STOP_DLY = 12'h004;
  localparam logic [11:0] OFF_RUN_DLY = 12'h008;
  localparam logic [11:0] OFF_CLR_SPD = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam int unsigned CTRL_DB_BIT = 0;
  localparam int unsigned ST_ON_BIT = 0;
  localparam int unsigned ST_BRK_BIT = 1;
  localparam int unsigned ST_PWR_BIT = 2;
  localparam int unsigned ST_DB_BIT = 3;
  localparam int unsigned ST_STATE_LSB = 4;
  localparam logic [15:0] RST_STOP_DLY = 16'h0000;
  localparam logic [15:0] RST_RUN_DLY = 16'h0000;
  localparam logic [15:0] RST_CLR_SPD = 16'h001E;
  localparam logic RST_DB_SEL = 1'b1;
  typedef enum logic [1:0] {
    BISQ_OFF = 2'b00,
    BISQ_ON = 2'b01,
    BISQ_STOP_DLY = 2'b10,
    BISQ_RUN_DLY = 2'b11
  } bisq_state_e;
endpackage

// File: test/bisq_brake_interlock_sequencer_tb.sv
// Self-checking bench for the brake interlock sequencer with a motor model.
// Assumes TICK of 4 cycles per ms and registered zero-wait APB answers.
`timescale 1ns/1ps
module bisq_brake_interlock_sequencer_tb;
  import bisq_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, son = 1'b0, alarm = 1'b0, mok = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic brake, power, dbrk, alm;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] target = 16'h0000, speed;
  int miscompares = 0, check_count = 0;
  always #12.5 clk = ~clk;
  bisq_brake_interlock_sequencer #(.TICK(4)) DUT (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_servo_on(son), .i_alarm(alarm), .i_main_power_ok(mok), .i_speed_rpm(speed),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_brake_release_request(brake), .o_motor_power(power), .o_dynamic_brake(dbrk),
    .o_alarm(alm));
  bisq_motor_model motor (.i_clk_sys(clk), .i_motor_power(power),
    .i_brake_release_request(brake), .i_target_rpm(target), .o_speed_rpm(speed));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Waits for pready without a cycle limit of its own; the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits on a settled output: 0 brake request, 1 motor power, 2 alarm
  task automatic wait_out(input int sel, input logic want, input int max);
    for (int n = 0; n < max; n++) begin
      @(negedge clk);
      if ((sel == 0 ? brake : sel == 1 ? power : alm) === want) break;
    end
  endtask
  task automatic set_son(input logic v);
    @(posedge clk);
    son <= v;
  endtask
  task automatic t_regs;
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk(rd, {31'h0000_0000, RST_DB_SEL});
    apb(1'b0, OFF_CLR_SPD, 32'h0000_0000);
    chk(rd, {16'h0000, RST_CLR_SPD});
    apb(1'b1, OFF_STOP_DLY, 32'h0000_0003);
    apb(1'b0, OFF_STOP_DLY, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    apb(1'b1, OFF_RUN_DLY, 32'hFFFF_0007);
    apb(1'b0, OFF_RUN_DLY, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    chk(dbrk, 1'b1);
    $display("test regs done");
  endtask
  task automatic t_on_off_stopped;
    set_son(1'b1);
    wait_out(0, 1'b1, 20);
    chk(brake, 1'b1);
    repeat (30) @(negedge clk);
    chk(power, 1'b1);
    chk(brake, 1'b1);
    chk(dbrk, 1'b0);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0017);
    set_son(1'b0);
    // Three ms of four cycles plus the sync and decision edges: drop due at the 16th edge
    repeat (14) @(negedge clk);
    chk(brake, 1'b1);
    chk(power, 1'b1);
    wait_out(0, 1'b0, 6);
    chk(brake, 1'b0);
    chk(power, 1'b0);
    chk(dbrk, 1'b1);
    $display("test stopped servo off done");
  endtask
  task automatic t_running;
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    apb(1'b1, OFF_RUN_DLY, 32'h0000_0005);
    apb(1'b1, OFF_CLR_SPD, 32'h0000_0064);
    target <= 16'h01F4;
    set_son(1'b1);
    wait_out(1, 1'b1, 20);
    repeat (3) @(negedge clk);
    set_son(1'b0);
    // Five ms of four cycles plus the sync and decision edges: drop due at the 24th edge
    repeat (22) @(negedge clk);
    chk(brake, 1'b1);
    chk(power, 1'b1);
    wait_out(0, 1'b0, 6);
    chk(brake, 1'b0);
    chk(power, 1'b0);
    chk(dbrk, 1'b0);
    set_son(1'b1);
    for (int n = 0; n < 40; n++) begin
      @(negedge clk);
      if (speed > {8'h00, SPEED_STOP_RPM}) chk(power, 1'b0);
    end
    wait_out(1, 1'b1, 30);
    chk(power, 1'b1);
    repeat (3) @(negedge clk);
    set_son(1'b0);
    repeat (5) @(posedge clk);
    target <= 16'h0032;
    wait_out(0, 1'b0, 8);
    chk(brake, 1'b0);
    target <= 16'h0000;
    repeat (60) @(negedge clk);
    $display("test running servo off done");
  endtask
  task automatic t_alarm;
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    target <= 16'h01F4;
    set_son(1'b1);
    wait_out(1, 1'b1, 20);
    repeat (3) @(negedge clk);
    @(posedge clk);
    alarm <= 1'b1;
    wait_out(2, 1'b1, 10);
    chk(alm, 1'b1);
    // Speed stays above the clear speed, so only the running delay may drop the brake
    repeat (15) @(negedge clk);
    chk(brake, 1'b1);
    wait_out(0, 1'b0, 30);
    chk(brake, 1'b0);
    chk(dbrk, 1'b1);
    @(posedge clk);
    alarm <= 1'b0;
    repeat (80) @(negedge clk);
    chk(alm, 1'b0);
    chk(power, 1'b0);
    set_son(1'b0);
    repeat (4) @(posedge clk);
    set_son(1'b1);
    wait_out(1, 1'b1, 20);
    chk(power, 1'b1);
    repeat (3) @(negedge clk);
    @(posedge clk);
    mok <= 1'b0;
    wait_out(2, 1'b1, 10);
    chk(alm, 1'b1);
    wait_out(0, 1'b0, 30);
    chk(brake, 1'b0);
    @(posedge clk);
    mok <= 1'b1;
    son <= 1'b0;
    $display("test alarm done");
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    t_regs;
    t_on_off_stopped;
    t_running;
    t_alarm;
    complete_run;
  end
endmodule // bisq_brake_interlock_sequencer_tb

// File: test/bisq_motor_model.sv
// Motor and normally closed holding brake at the far side of the sequencer.
// Assumes one clock; speed follows its target under torque and coasts down otherwise.
`timescale 1ns/1ps
module bisq_motor_model #(
  parameter int unsigned DECEL = 10
) (
  input wire logic i_clk_sys,
  input wire logic i_motor_power,
  input wire logic i_brake_release_request,
  input wire logic [15:0] i_target_rpm,
  output logic [15:0] o_speed_rpm
);
  logic [15:0] speed_reg = 16'h0000;
  // Torque only while energised with the brake released, so a stuck brake shows as a stall
  always @(posedge i_clk_sys) begin
    if (i_motor_power && i_brake_release_request) begin
      speed_reg <= i_target_rpm;
    end else if (speed_reg > 16'(DECEL)) begin
      speed_reg <= speed_reg - 16'(DECEL);
    end else begin
      speed_reg <= 16'h0000;
    end
  end
  assign o_speed_rpm = speed_reg;
endmodule // bisq_motor_model
